// ---- logic/lspe_defs.svh ----
// Register map, field positions, reset values and timing figures of the
// line section power enable block. Included by the package and the top module.
`ifndef LSPE_DEFS_SVH
`define LSPE_DEFS_SVH

`define LSPE_ADDR_W 8
`define LSPE_DATA_W 8
`define LSPE_NUM_CH 3

`define LSPE_CTL_OFS 8'h00
`define LSPE_STAT_OFS 8'h40

`define LSPE_CTL_RST 8'h00
`define LSPE_CTL_WR_MASK 8'h77
`define LSPE_TX_ON_LSB 0
`define LSPE_RX_ON_LSB 4

`define LSPE_STAT_PIN_LSB 0
`define LSPE_STAT_READY_LSB 4

`define LSPE_CLK_PERIOD_NS 10
`define LSPE_RX_SETTLE_NS 1000

`endif

// ---- logic/lspe_line_driver.sv ----
// One channel's transmit line driver: a registered output pair and enable.
// Assumes data comes from logic on ref_clk; the pad applies the enable.
`timescale 1ns/1ps

module lspe_line_driver (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic drvEnable,
	input wire logic dataPos,
	input wire logic dataNeg,
	output logic lineOutPos,
	output logic lineOutNeg,
	output logic lineOutOe
);

	logic pos_ff;
	logic neg_ff;
	logic oe_ff;

	// Disabled driver sends nothing and releases both pins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			oe_ff <= 1'b0;
		end else begin
			oe_ff <= drvEnable;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pos_ff <= 1'b0;
			neg_ff <= 1'b0;
		end else begin
			pos_ff <= drvEnable & dataPos;
			neg_ff <= drvEnable & dataNeg;
		end
	end

	assign lineOutPos = pos_ff;
	assign lineOutNeg = neg_ff;
	assign lineOutOe = oe_ff;

endmodule // lspe_line_driver

// ---- logic/lspe_pkg.sv ----
// Types shared by the line section power enable modules.
// Assumes the constants header is on the include path.
`include "lspe_defs.svh"

package lspe_pkg;

	typedef logic [`LSPE_DATA_W-1:0] lspe_reg_t;
	typedef logic [`LSPE_ADDR_W-1:0] lspe_addr_t;

	typedef enum logic [1:0] {
		LSPE_RX_OFF,
		LSPE_RX_WAKE,
		LSPE_RX_ON
	} lspe_rx_state_t;

endpackage

// ---- logic/lspe_power_enables.sv ----
// Top of the line section power enable block: control register, receive
// section power sequencing and transmit driver gating for three channels.
// Assumes a single-cycle register port on ref_clk; enable and receive line pins arrive asynchronously.
`timescale 1ns/1ps

`include "lspe_defs.svh"

module lspe_power_enables
	import lspe_pkg::*;
#(
	parameter int NUM_CH = `LSPE_NUM_CH,
	parameter int RX_SETTLE_NS = `LSPE_RX_SETTLE_NS
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [`LSPE_ADDR_W-1:0] regAddr,
	input wire logic [`LSPE_DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [`LSPE_DATA_W-1:0] regRdData,
	input wire logic [NUM_CH-1:0] txEnablePin,
	input wire logic [NUM_CH-1:0] txDataPos,
	input wire logic [NUM_CH-1:0] txDataNeg,
	output logic [NUM_CH-1:0] lineOutPos,
	output logic [NUM_CH-1:0] lineOutNeg,
	output logic [NUM_CH-1:0] lineOutOe,
	input wire logic [NUM_CH-1:0] lineInPos,
	input wire logic [NUM_CH-1:0] lineInNeg,
	output logic [NUM_CH-1:0] rxDataPos,
	output logic [NUM_CH-1:0] rxDataNeg,
	output logic [NUM_CH-1:0] rxPowerDown,
	output logic [NUM_CH-1:0] rxReady
);

	localparam int RX_SETTLE_CYC_RAW =
		(RX_SETTLE_NS + `LSPE_CLK_PERIOD_NS - 1) / `LSPE_CLK_PERIOD_NS;
	localparam int RX_SETTLE_CYC = (RX_SETTLE_CYC_RAW < 1) ? 1 : RX_SETTLE_CYC_RAW;
	localparam int CNT_W = $clog2(RX_SETTLE_CYC + 1);
	localparam int SYNC_W = 3 * NUM_CH;

	initial begin
		if (NUM_CH != `LSPE_NUM_CH) begin
			$error("lspe_power_enables: control layout serves exactly three channels");
		end
		if (RX_SETTLE_NS < 1) begin
			$error("lspe_power_enables: RX_SETTLE_NS must be positive");
		end
	end

	lspe_reg_t ctl_ff;
	lspe_reg_t rdData_ff;
	lspe_reg_t statusWord;
	logic [SYNC_W-1:0] syncBus;
	logic [NUM_CH-1:0] txPinSync;
	logic [NUM_CH-1:0] lineInPosSync;
	logic [NUM_CH-1:0] lineInNegSync;
	logic [NUM_CH-1:0] rxReadyInt;

	lspe_sync #(
		.WIDTH(SYNC_W)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.asyncIn({lineInNeg, lineInPos, txEnablePin}),
		.syncOut(syncBus)
	);

	assign txPinSync = syncBus[NUM_CH-1:0];
	assign lineInPosSync = syncBus[2*NUM_CH-1:NUM_CH];
	assign lineInNegSync = syncBus[3*NUM_CH-1:2*NUM_CH];

	// Control register: reserved bits never store
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctl_ff <= `LSPE_CTL_RST;
		end else if (regWr && regAddr == `LSPE_CTL_OFS) begin
			ctl_ff <= regWrData & `LSPE_CTL_WR_MASK;
		end
	end

	always_comb begin
		statusWord = '0;
		statusWord[`LSPE_STAT_PIN_LSB +: NUM_CH] = txPinSync;
		statusWord[`LSPE_STAT_READY_LSB +: NUM_CH] = rxReadyInt;
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdData_ff <= '0;
		end else if (regRd) begin
			case (regAddr)
				`LSPE_CTL_OFS: rdData_ff <= ctl_ff & `LSPE_CTL_WR_MASK;
				`LSPE_STAT_OFS: rdData_ff <= statusWord;
				default: rdData_ff <= '0;
			endcase
		end else begin
			rdData_ff <= '0;
		end
	end

	assign regRdData = rdData_ff;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			lspe_rx_state_t state_ff;
			logic [CNT_W-1:0] settle_ff;
			logic pdn_ff;
			logic ready_ff;
			logic rxPos_ff;
			logic rxNeg_ff;
			logic rxOn;

			assign rxOn = ctl_ff[`LSPE_RX_ON_LSB + ch];

			// Receive section power sequence; clearing the bit cuts it at once
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					state_ff <= LSPE_RX_OFF;
					settle_ff <= '0;
				end else begin
					case (state_ff)
						LSPE_RX_OFF: begin
							if (rxOn) begin
								state_ff <= LSPE_RX_WAKE;
								settle_ff <= CNT_W'(RX_SETTLE_CYC - 1);
							end
						end
						LSPE_RX_WAKE: begin
							if (!rxOn) begin
								state_ff <= LSPE_RX_OFF;
							end else if (settle_ff == '0) begin
								state_ff <= LSPE_RX_ON;
							end else begin
								settle_ff <= settle_ff - CNT_W'(1);
							end
						end
						LSPE_RX_ON: begin
							if (!rxOn) begin
								state_ff <= LSPE_RX_OFF;
							end
						end
						default: begin
							state_ff <= LSPE_RX_OFF;
						end
					endcase
				end
			end

			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					pdn_ff <= 1'b1;
					ready_ff <= 1'b0;
				end else begin
					pdn_ff <= !rxOn;
					ready_ff <= rxOn && state_ff == LSPE_RX_ON;
				end
			end

			// Line data passes only from a powered, settled section
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					rxPos_ff <= 1'b0;
					rxNeg_ff <= 1'b0;
				end else begin
					rxPos_ff <= rxOn && state_ff == LSPE_RX_ON && lineInPosSync[ch];
					rxNeg_ff <= rxOn && state_ff == LSPE_RX_ON && lineInNegSync[ch];
				end
			end

			assign rxPowerDown[ch] = pdn_ff;
			assign rxReady[ch] = ready_ff;
			assign rxReadyInt[ch] = ready_ff;
			assign rxDataPos[ch] = rxPos_ff;
			assign rxDataNeg[ch] = rxNeg_ff;

			lspe_line_driver u_drv (
				.ref_clk(ref_clk),
				.rst(rst),
				.drvEnable(txPinSync[ch] & ctl_ff[`LSPE_TX_ON_LSB + ch]),
				.dataPos(txDataPos[ch]),
				.dataNeg(txDataNeg[ch]),
				.lineOutPos(lineOutPos[ch]),
				.lineOutNeg(lineOutNeg[ch]),
				.lineOutOe(lineOutOe[ch])
			);
		end
	endgenerate

endmodule // lspe_power_enables

// ---- logic/lspe_sync.sv ----
// Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no word coherence is promised.
`timescale 1ns/1ps

module lspe_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	initial begin
		if (WIDTH < 1) begin
			$error("lspe_sync: WIDTH must be at least 1");
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= asyncIn;
			stage2_ff <= stage1_ff;
		end
	end

	assign syncOut = stage2_ff;

endmodule // lspe_sync

// ---- verification/lspe_power_enables_chk.sv ----
// Checker for the line section power enable block.
// Sees only top ports; bound from the bench top file.
`timescale 1ns/1ps
module lspe_power_enables_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	input wire logic [2:0] txEnablePin,
	input wire logic [2:0] lineOutPos,
	input wire logic [2:0] lineOutNeg,
	input wire logic [2:0] lineOutOe,
	input wire logic [2:0] rxDataPos,
	input wire logic [2:0] rxDataNeg,
	input wire logic [2:0] rxPowerDown,
	input wire logic [2:0] rxReady
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [7:0] ctlMirror_ff;
	always_ff @(posedge ref_clk or posedge rst)
		if (rst) ctlMirror_ff <= 8'h00;
		else if (regWr && regAddr == 8'h00) ctlMirror_ff <= regWrData & 8'h77;
	sequence ctlWr; regWr && regAddr == 8'h00; endsequence
	sequence ctlRd; regRd && regAddr == 8'h00; endsequence
	chk_ctl_readback: assert property (ctlRd |=> regRdData == $past(ctlMirror_ff))
		else $error("control readback wrong");
	chk_reset_state: assert property ($fell(rst) |-> rxPowerDown == 3'h7 && lineOutOe == 3'h0)
		else $error("state after reset wrong");
	chk_rx_power: assert property (ctlWr |-> ##2 rxPowerDown == ~$past(regWrData[6:4], 2))
		else $error("receive power wrong");
	chk_oe_bit: assert property (ctlWr |-> ##2 (lineOutOe & ~$past(regWrData[2:0], 2)) == 3'h0)
		else $error("driver on with bit clear");
	chk_oe_pin: assert property ((lineOutOe & ~(txEnablePin | $past(txEnablePin)
		| $past(txEnablePin, 2) | $past(txEnablePin, 3))) == 3'h0)
		else $error("driver on with pin low");
	chk_line_quiet: assert property (((lineOutPos | lineOutNeg) & ~lineOutOe) == 3'h0)
		else $error("line active while off");
	chk_rx_gate: assert property (((rxDataPos | rxDataNeg) & ~rxReady) == 3'h0)
		else $error("receive data while not ready");
	chk_ready_power: assert property ((rxReady & rxPowerDown) == 3'h0)
		else $error("ready while powered down");
endmodule // lspe_power_enables_chk

// ---- verification/lspe_power_enables_tb.sv ----
// Bench for the line section power enable block.
// Drives every port itself; checker bound at the foot.
`timescale 1ns/1ps
module lspe_power_enables_tb import lspe_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic rdPend = 1'b0;
	lspe_addr_t regAddr = 8'h00;
	lspe_reg_t regWrData = 8'h00;
	lspe_reg_t regRdData;
	logic [2:0] txEnablePin = 3'h0, txDataPos = 3'h0, txDataNeg = 3'h0;
	logic [2:0] lineInPos = 3'h0, lineInNeg = 3'h0;
	logic [2:0] lineOutPos, lineOutNeg, lineOutOe, rxDataPos, rxDataNeg, rxPowerDown, rxReady;
	int fails = 0;
	int n_checks = 0;
	logic [31:0] seed = 32'h1A;
	lspe_reg_t expQ[$];
	lspe_reg_t d;
	lspe_power_enables #(.RX_SETTLE_NS(50)) i_dut (.ref_clk, .rst, .regAddr, .regWrData,
		.regWr, .regRd, .regRdData, .txEnablePin, .txDataPos, .txDataNeg, .lineOutPos,
		.lineOutNeg, .lineOutOe, .lineInPos, .lineInNeg, .rxDataPos, .rxDataNeg,
		.rxPowerDown, .rxReady);
	always #5 ref_clk = ~ref_clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic cmp(input lspe_reg_t got, input lspe_reg_t exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input lspe_addr_t a, input lspe_reg_t v);
		regWr <= 1'b1;
		regRd <= 1'b0;
		regAddr <= a;
		regWrData <= v;
		@(posedge ref_clk);
	endtask
	task automatic rd(input lspe_addr_t a, input lspe_reg_t e);
		expQ.push_back(e);
		regRd <= 1'b1;
		regWr <= 1'b0;
		regAddr <= a;
		@(posedge ref_clk);
	endtask
	task automatic idle(input int n);
		regWr <= 1'b0;
		regRd <= 1'b0;
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic end_sim;
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		if (rdPend) cmp(regRdData, expQ.pop_front());
		rdPend <= regRd;
	end
	initial begin
		#200000;
		fails++;
		end_sim();
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		idle(1);
		cmp({5'h0, lineOutOe}, 8'h00);
		cmp({5'h0, rxPowerDown}, 8'h07);
		@(posedge ref_clk);
		rd(8'h00, 8'h00);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h77);
		rd(8'h3F, 8'h00);
		wr(8'h40, 8'h00);
		rd(8'h00, 8'h77);
		$display("test reset and reserved done");
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			d = seed[7:0];
			txEnablePin <= seed[10:8];
			txDataPos <= seed[13:11];
			txDataNeg <= seed[16:14];
			lineInPos <= seed[19:17];
			lineInNeg <= seed[22:20];
			wr(8'h00, d);
			idle(4);
			cmp({5'h0, lineOutOe}, {5'h0, seed[10:8] & d[2:0]});
			cmp({5'h0, lineOutPos}, {5'h0, seed[10:8] & d[2:0] & seed[13:11]});
			cmp({5'h0, lineOutNeg}, {5'h0, seed[10:8] & d[2:0] & seed[16:14]});
			cmp({5'h0, rxPowerDown}, {5'h0, ~d[6:4]});
			@(posedge ref_clk);
			rd(8'h00, d & 8'h77);
		end
		$display("test random enables done");
		txEnablePin <= 3'h2;
		txDataPos <= 3'h2;
		txDataNeg <= 3'h6;
		lineInPos <= 3'h5;
		lineInNeg <= 3'h6;
		wr(8'h00, 8'h70);
		idle(30);
		cmp({5'h0, rxReady}, 8'h07);
		cmp({5'h0, rxDataPos}, 8'h05);
		cmp({5'h0, rxDataNeg}, 8'h06);
		cmp({5'h0, lineOutOe}, 8'h00);
		cmp({5'h0, lineOutPos | lineOutNeg}, 8'h00);
		@(posedge ref_clk);
		rd(8'h40, 8'h72);
		wr(8'h00, 8'h02);
		idle(4);
		cmp({5'h0, rxReady}, 8'h00);
		cmp({5'h0, lineOutOe}, 8'h02);
		cmp({5'h0, lineOutPos}, 8'h02);
		cmp({5'h0, lineOutNeg}, 8'h02);
		$display("test receive wake done");
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		idle(1);
		cmp({5'h0, lineOutOe}, 8'h00);
		cmp({5'h0, rxPowerDown}, 8'h07);
		@(posedge ref_clk);
		rd(8'h00, 8'h00);
		idle(2);
		$display("test mid-run reset done");
		end_sim();
	end
endmodule // lspe_power_enables_tb
bind lspe_power_enables lspe_power_enables_chk i_chk (.ref_clk, .rst, .regAddr, .regWrData,
	.regWr, .regRd, .regRdData, .txEnablePin, .lineOutPos, .lineOutNeg, .lineOutOe,
	.rxDataPos, .rxDataNeg, .rxPowerDown, .rxReady);
